//--- bench/dual_clock_fifo_port_control_tb_top.sv
// Self-checking bench for the FIFO port controller.
`timescale 1ns/100ps
module dual_clock_fifo_port_control_tb_top import fifo_port_pkg::*;;
  logic              CLOCK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, INPUT_DATA_GATE, OE_N;
  logic              CONFIG_SELECT_N, MARK, REPLAY_REQUEST, wr_req, rd_req, rude;
  logic              WB_ACK_O, IRQ, WR_EN, RD_EN, Q_OE, EMPTY_FLAG_N, FULL_FLAG_N;
  logic [WB_AW-1:0]  WB_ADR_I;
  logic [3:0]        WB_SEL_I;
  logic [WB_DW-1:0]  WB_DAT_I, WB_DAT_O, r;
  logic [DATA_W-1:0] D, Q;
  int                mismatches, n_checks, cycles;
  int                pat_exp[3] = '{30, 1, 31};
  fifo_port_ctrl #(.ADDR_W(4)) u_dut (.CLOCK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ, .WR_EN, .INPUT_DATA_GATE,
    .D, .RD_EN, .OE_N, .Q, .Q_OE, .CONFIG_SELECT_N, .MARK, .REPLAY_REQUEST, .EMPTY_FLAG_N,
    .FULL_FLAG_N);
  port_host u_host (.wr_req, .rd_req, .rude, .cfg_n(CONFIG_SELECT_N), .empty_n(EMPTY_FLAG_N),
    .full_n(FULL_FLAG_N), .wr_en(WR_EN), .rd_en(RD_EN));
  function automatic logic [35:0] pat(input int i);
    return 36'h8_c3c3_c3c0 + 36'(i);
  endfunction
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One Wishbone classic cycle; read data is taken at the acknowledging edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    if (WB_ACK_O !== 1'b1) mismatches++;
    r = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLOCK);
  endtask
  // One port request for a single edge, then one idle edge so outputs are settled.
  task automatic op(input logic w, rd, g, s, m, p, input logic [35:0] d);
    wr_req <= w;
    rd_req <= rd;
    INPUT_DATA_GATE <= g;
    CONFIG_SELECT_N <= s;
    MARK <= m;
    REPLAY_REQUEST <= p;
    D <= d;
    @(posedge CLOCK);
    {wr_req, rd_req, MARK, REPLAY_REQUEST, CONFIG_SELECT_N} <= 5'h01;
    @(posedge CLOCK);
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {NRST, WB_CYC_I, WB_STB_I, WB_WE_I, INPUT_DATA_GATE, OE_N, MARK} = 7'h00;
    {REPLAY_REQUEST, wr_req, rd_req, rude, CONFIG_SELECT_N} = 5'h01;
    {WB_ADR_I, WB_DAT_I, D, cycles, mismatches, n_checks} = '0;
    WB_SEL_I = 4'hf;
    repeat (10) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    chk("empty", EMPTY_FLAG_N, 1'b0);
    chk("full", FULL_FLAG_N, 1'b1);
    for (int i = 0; i < 16; i++) op(1, 0, 1, 1, 0, 0, pat(i));
    chk("full", FULL_FLAG_N, 1'b0);
    rude <= 1'b1;
    op(1, 0, 1, 1, 0, 0, 36'h0);
    rude <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      op(0, 1, 1, 1, 0, 0, 36'h0);
      chk("q", Q, pat(i));
    end
    chk("empty", EMPTY_FLAG_N, 1'b0);
    rude <= 1'b1;
    op(0, 1, 1, 1, 0, 0, 36'h0);
    rude <= 1'b0;
    chk("q held", Q, pat(15));
    wb(0, ADR_STATUS, 32'h0);
    chk("status", r[2:0] & 3'h3, 36'h3);
    chk("irq", IRQ, 1'b0);
    wb(1, ADR_MASK, 32'h2);
    chk("irq", IRQ, 1'b1);
    wb(1, ADR_STATUS, 32'h3);
    chk("irq", IRQ, 1'b0);
    wb(0, 8'h40, 32'h0);
    chk("unmapped", r, 36'h0);
    op(1, 0, 1, 1, 0, 0, pat(30));
    op(1, 0, 0, 1, 0, 0, 36'h0);
    op(1, 0, 1, 1, 0, 0, pat(31));
    foreach (pat_exp[k]) begin
      op(0, 1, 1, 1, 0, 0, 36'h0);
      chk("gated", Q, pat(pat_exp[k]));
    end
    op(1, 0, 1, 0, 0, 0, 36'hf_ffff_ff5a);
    op(0, 1, 1, 0, 0, 0, 36'h0);
    chk("cfg q", Q, 36'h5a);
    chk("empty", EMPTY_FLAG_N, 1'b0);
    wb(0, ADR_CONFIG, 32'h0);
    chk("cfg", r[7:0], 36'h5a);
    for (int i = 0; i < 3; i++) op(1, 0, 1, 1, 0, 0, pat(20 + i));
    op(0, 1, 1, 1, 0, 0, 36'h0);
    op(0, 0, 1, 1, 1, 0, 36'h0);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) op(0, 0, 1, 1, 0, 1, 36'h0);
      chk("replay empty", EMPTY_FLAG_N, 1'b1);
      op(0, 1, 1, 1, 0, 0, 36'h0);
      chk("replay q", Q, pat(21 + k % 2));
    end
    chk("replay end", EMPTY_FLAG_N, 1'b0);
    wb(0, ADR_STATUS, 32'h0);
    chk("replay evt", r[2], 1'b1);
    wb(0, ADR_LEVEL, 32'h0);
    chk("level", r[18:16], 3'h6);
    chk("used", r[4:0], 5'h2);
    wb(1, ADR_CTRL, 32'h1);
    wb(0, ADR_LEVEL, 32'h0);
    chk("flushed", r[18:0], 19'h20000);
    OE_N <= 1'b1;
    @(posedge CLOCK);
    chk("oe off", Q_OE, 1'b0);
    OE_N <= 1'b0;
    @(posedge CLOCK);
    chk("oe on", Q_OE, 1'b1);
    conclude();
  end
endmodule

//--- bench/port_host.sv
// Host-side model that gates port requests by the queue flags.
`timescale 1ns/100ps
module port_host (
  input  wire logic wr_req,
  input  wire logic rd_req,
  input  wire logic rude,
  input  wire logic cfg_n,
  input  wire logic empty_n,
  input  wire logic full_n,
  output logic      wr_en,
  output logic      rd_en
);
  // A request is held back by the flag unless a scenario asks for a rude one or config select is active.
  assign wr_en = wr_req & (full_n | rude | ~cfg_n);
  assign rd_en = rd_req & (empty_n | rude | ~cfg_n);
endmodule

//--- logic/fifo_port_ctrl.sv
// FIFO with gated write and read ports, mark and replay, flags and a Wishbone register slave.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module fifo_port_ctrl
  import fifo_port_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [WB_AW-1:0]  WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [WB_DW-1:0]  WB_DAT_I,
  output logic      [WB_DW-1:0]  WB_DAT_O,
  output logic                   WB_ACK_O,
  output logic                   IRQ,
  input  wire logic              WR_EN,
  input  wire logic              INPUT_DATA_GATE,
  input  wire logic [DATA_W-1:0] D,
  input  wire logic              RD_EN,
  input  wire logic              OE_N,
  output logic      [DATA_W-1:0] Q,
  output logic                   Q_OE,
  input  wire logic              CONFIG_SELECT_N,
  input  wire logic              MARK,
  input  wire logic              REPLAY_REQUEST,
  output logic                   EMPTY_FLAG_N,
  output logic                   FULL_FLAG_N
);
  localparam int          DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W:0] DEPTH_P = (ADDR_W+1)'(DEPTH);
  localparam logic [ADDR_W:0] ONE_P   = (ADDR_W+1)'(1);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W:0]   wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt, mark_ptr_r, mark_ptr_nxt;
  logic [ADDR_W:0]   base_nxt, used;
  logic              mark_valid_r, mark_valid_nxt;
  logic              empty_flag_n_r, full_flag_n_r;
  logic [CFG_W-1:0]  cfg_r;
  logic [DATA_W-1:0] q_r;
  logic [EVT_W-1:0]  status_r, mask_r, evt;
  logic              flush_r, ack_r;
  logic [WB_DW-1:0]  dat_o_r, rd_mux;
  logic              wb_req, wb_wr, fifo_wr, fifo_rd, wr_step, rd_step, replay;

  assign wb_req  = WB_CYC_I & WB_STB_I;
  assign wb_wr   = wb_req & WB_WE_I & ack_r & WB_SEL_I[0];
  assign fifo_wr = WR_EN & CONFIG_SELECT_N;
  assign fifo_rd = RD_EN & CONFIG_SELECT_N;
  assign wr_step = fifo_wr & full_flag_n_r;
  assign rd_step = fifo_rd & empty_flag_n_r;
  assign replay  = REPLAY_REQUEST & mark_valid_r;
  assign used    = wr_ptr_r - (mark_valid_r ? mark_ptr_r : rd_ptr_r);

  always_comb begin
    wr_ptr_nxt     = wr_ptr_r;
    rd_ptr_nxt     = rd_ptr_r;
    mark_ptr_nxt   = mark_ptr_r;
    mark_valid_nxt = mark_valid_r;
    if (wr_step) begin
      wr_ptr_nxt = wr_ptr_r + ONE_P;
    end
    if (replay) begin
      rd_ptr_nxt = mark_ptr_r;
    end else if (rd_step) begin
      rd_ptr_nxt = rd_ptr_r + ONE_P;
    end
    if (MARK) begin
      mark_ptr_nxt   = rd_ptr_r;
      mark_valid_nxt = 1'b1;
    end
    if (flush_r) begin
      wr_ptr_nxt     = '0;
      rd_ptr_nxt     = '0;
      mark_ptr_nxt   = '0;
      mark_valid_nxt = 1'b0;
    end
    base_nxt = mark_valid_nxt ? mark_ptr_nxt : rd_ptr_nxt;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wr_ptr_r     <= '0;
      rd_ptr_r     <= '0;
      mark_ptr_r   <= '0;
      mark_valid_r <= 1'b0;
    end else begin
      wr_ptr_r     <= wr_ptr_nxt;
      rd_ptr_r     <= rd_ptr_nxt;
      mark_ptr_r   <= mark_ptr_nxt;
      mark_valid_r <= mark_valid_nxt;
    end
  end

  // Flags are registered on the same clock as the pointers.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      empty_flag_n_r <= 1'b0;
      full_flag_n_r  <= 1'b1;
    end else begin
      empty_flag_n_r <= (wr_ptr_nxt != rd_ptr_nxt);
      full_flag_n_r  <= ((wr_ptr_nxt - base_nxt) != DEPTH_P);
    end
  end

  // The gate masks the store only; the pointer still steps.
  always_ff @(posedge CLOCK) begin
    if (wr_step && INPUT_DATA_GATE) begin
      mem[wr_ptr_r[ADDR_W-1:0]] <= D;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q_r <= '0;
    end else if (RD_EN && !CONFIG_SELECT_N) begin
      q_r <= {{(DATA_W-CFG_W){1'b0}}, cfg_r};
    end else if (rd_step) begin
      q_r <= mem[rd_ptr_r[ADDR_W-1:0]];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= CFG_RESET;
    end else if (WR_EN && !CONFIG_SELECT_N) begin
      cfg_r <= D[CFG_W-1:0];
    end else if (wb_wr && WB_ADR_I == ADR_CONFIG) begin
      cfg_r <= WB_DAT_I[CFG_W-1:0];
    end
  end

  assign Q            = q_r;
  assign Q_OE         = ~OE_N;
  assign EMPTY_FLAG_N = empty_flag_n_r;
  assign FULL_FLAG_N  = full_flag_n_r;

  always_comb begin
    evt               = '0;
    evt[EVT_OVERFLOW] = fifo_wr & ~full_flag_n_r;
    evt[EVT_UNDERRUN] = fifo_rd & ~empty_flag_n_r;
    evt[EVT_REPLAY]   = replay;
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      status_r <= EVT_RESET;
    end else if (wb_wr && WB_ADR_I == ADR_STATUS) begin
      status_r <= (status_r & ~WB_DAT_I[EVT_W-1:0]) | evt;
    end else begin
      status_r <= status_r | evt;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      mask_r  <= EVT_RESET;
      flush_r <= 1'b0;
    end else begin
      if (wb_wr && WB_ADR_I == ADR_MASK) begin
        mask_r <= WB_DAT_I[EVT_W-1:0];
      end
      flush_r <= wb_wr && WB_ADR_I == ADR_CTRL && WB_DAT_I[CTRL_FLUSH];
    end
  end

  assign IRQ = |(status_r & mask_r);

  always_comb begin
    rd_mux = '0;
    unique case (WB_ADR_I)
      ADR_STATUS: rd_mux[EVT_W-1:0] = status_r;
      ADR_MASK:   rd_mux[EVT_W-1:0] = mask_r;
      ADR_LEVEL: begin
        rd_mux[ADDR_W:0]    = used;
        rd_mux[LVL_EMPTY_N] = empty_flag_n_r;
        rd_mux[LVL_FULL_N]  = full_flag_n_r;
        rd_mux[LVL_MARKED]  = mark_valid_r;
      end
      ADR_CONFIG: rd_mux[CFG_W-1:0] = cfg_r;
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ack_r   <= 1'b0;
      dat_o_r <= '0;
    end else begin
      ack_r <= wb_req & ~ack_r;
      if (wb_req && !ack_r) begin
        dat_o_r <= rd_mux;
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_o_r;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_masked_write;
    WR_EN && CONFIG_SELECT_N && full_flag_n_r && !INPUT_DATA_GATE && !flush_r;
  endsequence

  a_write_gated: assert property (!WR_EN && !flush_r |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("write pointer moved without write enable");
  a_read_gated: assert property (!RD_EN && !replay && !flush_r |=> rd_ptr_r == $past(rd_ptr_r))
    else $error("read pointer moved without read enable");
  a_pointer_skip: assert property (s_masked_write |=> wr_ptr_r == $past(wr_ptr_r) + ONE_P)
    else $error("masked write did not step the pointer");
  a_word_stored: assert property (wr_step && INPUT_DATA_GATE |=>
    mem[$past(wr_ptr_r[ADDR_W-1:0])] == $past(D))
    else $error("gated write not stored");
  a_output_float: assert property (OE_N |-> !Q_OE)
    else $error("outputs driven while disabled");
  a_config_write: assert property (WR_EN && !CONFIG_SELECT_N |=> cfg_r == $past(D[CFG_W-1:0]))
    else $error("config write lost");
  a_config_read: assert property (RD_EN && !CONFIG_SELECT_N |=>
    Q == {{(DATA_W-CFG_W){1'b0}}, $past(cfg_r)})
    else $error("config read wrong");
  a_empty_flag: assert property (EMPTY_FLAG_N == (wr_ptr_r != rd_ptr_r))
    else $error("empty flag wrong");
  a_full_flag: assert property (FULL_FLAG_N == (used != DEPTH_P))
    else $error("full flag wrong");
  a_replay_rewind: assert property (replay && !flush_r |=> rd_ptr_r == $past(mark_ptr_r))
    else $error("replay did not rewind");

  // Further checks on the bus answer, the mark and the flag edges.
  sequence s_bus_request;
    wb_req && !ack_r;
  endsequence

  sequence s_fifo_read;
    rd_step && !replay && !flush_r;
  endsequence

  sequence s_refused_write;
    fifo_wr && !full_flag_n_r && !flush_r;
  endsequence

  sequence s_refused_read;
    fifo_rd && !empty_flag_n_r && !replay && !flush_r;
  endsequence

  a_ack_answer: assert property (s_bus_request |=>
    WB_ACK_O)
    else $error("bus request not acknowledged");

  a_ack_pulse: assert property (WB_ACK_O |=>
    !WB_ACK_O)
    else $error("acknowledge held too long");

  a_mark_record: assert property (MARK && !flush_r |=>
    mark_valid_r && mark_ptr_r == $past(rd_ptr_r))
    else $error("mark not recorded");

  a_read_step: assert property (s_fifo_read |=>
    rd_ptr_r == $past(rd_ptr_r) + ONE_P)
    else $error("read pointer did not step");

  a_fifo_data: assert property (s_fifo_read |=>
    Q == $past(mem[rd_ptr_r[ADDR_W-1:0]]))
    else $error("fifo read data wrong");

  a_full_refused: assert property (s_refused_write |=>
    wr_ptr_r == $past(wr_ptr_r))
    else $error("write accepted while full");

  a_empty_refused: assert property (s_refused_read |=>
    rd_ptr_r == $past(rd_ptr_r) && Q == $past(Q))
    else $error("read accepted while empty");

  a_flush_clears: assert property (flush_r |=>
    wr_ptr_r == '0 && rd_ptr_r == '0 && !mark_valid_r)
    else $error("flush did not clear pointers");

  a_replay_ignored: assert property (REPLAY_REQUEST && !mark_valid_r && !rd_step && !flush_r |=>
    rd_ptr_r == $past(rd_ptr_r))
    else $error("replay without mark moved pointer");

  a_output_drive: assert property (!OE_N |->
    Q_OE)
    else $error("outputs not driven while enabled");

  a_q_stable: assert property (!RD_EN |=>
    Q == $past(Q))
    else $error("read data changed without read enable");

  a_status_sticky: assert property (!(wb_wr && WB_ADR_I == ADR_STATUS) |=>
    (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit lost without clear");

  a_event_wins: assert property (1'b1 |=>
    (status_r & $past(evt)) == $past(evt))
    else $error("event not recorded in status");

  a_mem_untouched: assert property (s_masked_write |=>
    mem[$past(wr_ptr_r[ADDR_W-1:0])] == $past(mem[wr_ptr_r[ADDR_W-1:0]]))
    else $error("masked write changed memory");

  a_cfg_held: assert property (!(WR_EN && !CONFIG_SELECT_N) &&
    !(wb_wr && WB_ADR_I == ADR_CONFIG) |=> cfg_r == $past(cfg_r))
    else $error("config changed without a write");

  a_full_fall: assert property ($fell(FULL_FLAG_N) |->
    $past(wr_step || MARK))
    else $error("full flag fell without a write");

  a_empty_rise: assert property ($rose(EMPTY_FLAG_N) |->
    $past(wr_step || replay))
    else $error("empty flag rose without a write");

  a_mark_cap: assert property (mark_valid_r |->
    (wr_ptr_r - mark_ptr_r) <= DEPTH_P)
    else $error("marked data overwritten");
endmodule

//--- logic/fifo_port_pkg.sv
// Shared constants for the FIFO port controller.
package fifo_port_pkg;
  localparam int          DATA_W       = 36;
  localparam int          CFG_W        = 8;
  localparam int          WB_AW        = 8;
  localparam int          WB_DW        = 32;
  localparam int          EVT_W        = 3;
  localparam logic [7:0]  ADR_STATUS   = 8'h00;
  localparam logic [7:0]  ADR_MASK     = 8'h04;
  localparam logic [7:0]  ADR_CTRL     = 8'h08;
  localparam logic [7:0]  ADR_LEVEL    = 8'h0c;
  localparam logic [7:0]  ADR_CONFIG   = 8'h10;
  localparam int          EVT_OVERFLOW = 0;
  localparam int          EVT_UNDERRUN = 1;
  localparam int          EVT_REPLAY   = 2;
  localparam int          CTRL_FLUSH   = 0;
  localparam int          LVL_EMPTY_N  = 16;
  localparam int          LVL_FULL_N   = 17;
  localparam int          LVL_MARKED   = 18;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [2:0]  EVT_RESET    = 3'h0;
endpackage
